// >>> hw/sgfr_pkg.sv
// Purpose: shared constants and types for speed gain and flow ramp
// Assumes: 200 MHz clock, classic wishbone register access
// Notes: flow is signed, full scale 1000 units of 0.1 %
package sgfr_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SPAN = 8'h04;
	localparam logic [7:0] ADDR_GAIN0 = 8'h08;
	localparam logic [7:0] ADDR_RISE_MS = 8'h20;
	localparam logic [7:0] ADDR_FALL_MS = 8'h24;
	localparam logic [7:0] ADDR_FAST_MS = 8'h28;
	localparam logic [7:0] ADDR_ABORT_MS = 8'h2c;
	localparam logic [7:0] ADDR_BAND = 8'h30;
	localparam logic [7:0] ADDR_THRESH = 8'h34;
	localparam logic [7:0] ADDR_STATUS = 8'h38;
	localparam logic [7:0] ADDR_GAIN_OUT = 8'h3c;
	localparam logic [7:0] ADDR_FLOW_OUT = 8'h40;
	// ctrl fields
	localparam int SENS_LSB = 0;
	localparam int RAMP_LSB = 4;
	localparam int RISE_SHAPE_LSB = 8;
	localparam int FALL_SHAPE_LSB = 12;
	// ****************************************
	// reset values, field codes and limits
	// ****************************************
	localparam logic [1:0] SENS_RST = 2'h1;
	localparam logic [1:0] SENS_SPEED = 2'h3;
	localparam logic [1:0] RAMP_RST = 2'h0;
	localparam logic [1:0] RAMP_OFF = 2'h0;
	localparam logic [1:0] RAMP_FIXED = 2'h1;
	localparam logic [1:0] RAMP_SPEED = 2'h2;
	localparam logic [10:0] SPAN_RST = 11'h1f4;
	localparam logic [10:0] SPAN_MIN = 11'h001;
	localparam logic [10:0] SPAN_MAX = 11'h3e8;
	localparam logic [10:0] GAIN_MIN = 11'h014;
	localparam logic [10:0] GAIN_MAX = 11'h4b0;
	localparam logic [10:0] GAIN0_RST = 11'h069;
	localparam logic [10:0] GAIN1_RST = 11'h05a;
	localparam logic [10:0] GAIN2_RST = 11'h04b;
	localparam logic [10:0] GAIN3_RST = 11'h03c;
	localparam logic [10:0] GAIN4_RST = 11'h02d;
	localparam logic [10:0] GAIN5_RST = 11'h01e;
	localparam logic [10:0] RISE_MS_RST = 11'h001;
	localparam logic [10:0] FALL_MS_RST = 11'h15e;
	localparam logic [10:0] FAST_MS_RST = 11'h064;
	localparam logic [10:0] ABORT_MS_RST = 11'h001;
	localparam logic [10:0] MS_MAX = 11'h3e8;
	localparam logic [10:0] BAND_RST = 11'h3e8;
	localparam logic [10:0] THRESH_RST = 11'h000;
	localparam logic [10:0] THRESH_MAX = 11'h1f4;
	localparam logic [10:0] FULL_FLOW = 11'h3e8;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 200;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0]
	{
		RS_IDLE = 4'b0001,
		RS_RISE = 4'b0010,
		RS_FALL = 4'b0100,
		RS_ABORT = 4'b1000
	} sgfr_ramp_e;
	typedef struct packed
	{
		logic [31:0] dat;
		logic [7:0] adr;
		logic [3:0] sel;
		logic we;
		logic stb;
		logic cyc;
	} sgfr_wb_req_s;
endpackage

// >>> hw/sgfr_top.sv
// Purpose: speed scheduled steering gain and anti-jerk flow ramp
// Assumes: inputs are asynchronous to clk_i, sampled each clock
// Notes: registers over classic wishbone, ack one cycle after request
`timescale 1ns/1ps
`default_nettype none
module sgfr_top #(
	parameter int TICK_CYC = sgfr_pkg::TICK_CYCLES
)(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire sgfr_pkg::sgfr_wb_req_s wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic signed [15:0] road_speed_input_i,
	input wire logic signed [15:0] steer_input_i,
	input wire logic signed [15:0] requested_flow_i,
	output logic signed [15:0] steer_scaled_o,
	output logic signed [15:0] spool_setpoint_o
);
	// ****************************************
	// reset and input sync
	// ****************************************
	logic [1:0] rst_sync;
	wire rst_n = rst_sync[1];
	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	logic signed [15:0] spd_s [3];
	logic signed [15:0] str_s [3];
	logic signed [15:0] req_s [3];
	logic signed [15:0] spd_q, str_q, req_q;
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			spd_s <= '{default: 16'h0000};
			str_s <= '{default: 16'h0000};
			req_s <= '{default: 16'h0000};
			spd_q <= 16'h0000;
			str_q <= 16'h0000;
			req_q <= 16'h0000;
		end
		else
		begin
			spd_s <= '{road_speed_input_i, spd_s[0], spd_s[1]};
			str_s <= '{steer_input_i, str_s[0], str_s[1]};
			req_s <= '{requested_flow_i, req_s[0], req_s[1]};
			if (spd_s[1] == spd_s[2])
				spd_q <= spd_s[2];
			if (str_s[1] == str_s[2])
				str_q <= str_s[2];
			if (req_s[1] == req_s[2])
				req_q <= req_s[2];
		end
	// ****************************************
	// registers
	// ****************************************
	logic [15:0] ctrl;
	logic [10:0] span, rise_ms, fall_ms, fast_ms, abort_ms, band, thresh;
	logic [10:0] gain [6];
	wire wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	wire wb_wr = wb_hit && wb_req_i.we && (wb_req_i.sel[1:0] == 2'h3);
	wire [10:0] wd = wb_req_i.dat[10:0];
	wire [7:0] ga = wb_req_i.adr - sgfr_pkg::ADDR_GAIN0;
	wire g_hit = (wb_req_i.adr >= sgfr_pkg::ADDR_GAIN0) && (ga < 8'h18)
		&& (ga[1:0] == 2'h0);
	wire [2:0] gi = ga[4:2];
	wire [10:0] g_prev = (gi == 3'h0) ? sgfr_pkg::GAIN_MAX : gain[gi - 3'h1];
	wire [10:0] g_top = (gi == 3'h0) ? sgfr_pkg::GAIN_MAX : g_prev;
	wire [10:0] g_new = (wd < sgfr_pkg::GAIN_MIN) ? sgfr_pkg::GAIN_MIN
		: (wd > g_top) ? g_top : wd;
	wire [10:0] span_new = (wd < sgfr_pkg::SPAN_MIN) ? sgfr_pkg::SPAN_MIN
		: (wd > sgfr_pkg::SPAN_MAX) ? sgfr_pkg::SPAN_MAX : wd;
	wire [10:0] ms_new = (wd == 11'h000) ? 11'h001
		: (wd > sgfr_pkg::MS_MAX) ? sgfr_pkg::MS_MAX : wd;
	wire [10:0] band_new = (wd > sgfr_pkg::FULL_FLOW) ? sgfr_pkg::FULL_FLOW : wd;
	wire [10:0] thr_new = (wd > sgfr_pkg::THRESH_MAX) ? sgfr_pkg::THRESH_MAX
		: wd;
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			ctrl <= {4'h0, 4'h0, 2'h0, sgfr_pkg::RAMP_RST, 2'h0,
				sgfr_pkg::SENS_RST};
			span <= sgfr_pkg::SPAN_RST;
			rise_ms <= sgfr_pkg::RISE_MS_RST;
			fall_ms <= sgfr_pkg::FALL_MS_RST;
			fast_ms <= sgfr_pkg::FAST_MS_RST;
			abort_ms <= sgfr_pkg::ABORT_MS_RST;
			band <= sgfr_pkg::BAND_RST;
			thresh <= sgfr_pkg::THRESH_RST;
			gain <= '{sgfr_pkg::GAIN0_RST, sgfr_pkg::GAIN1_RST,
				sgfr_pkg::GAIN2_RST, sgfr_pkg::GAIN3_RST,
				sgfr_pkg::GAIN4_RST, sgfr_pkg::GAIN5_RST};
		end
		else if (wb_wr)
		begin
			case (wb_req_i.adr)
				sgfr_pkg::ADDR_CTRL: ctrl <= wb_req_i.dat[15:0];
				sgfr_pkg::ADDR_SPAN: span <= span_new;
				sgfr_pkg::ADDR_RISE_MS: rise_ms <= ms_new;
				sgfr_pkg::ADDR_FALL_MS: fall_ms <= ms_new;
				sgfr_pkg::ADDR_FAST_MS: fast_ms <= ms_new;
				sgfr_pkg::ADDR_ABORT_MS: abort_ms <= ms_new;
				sgfr_pkg::ADDR_BAND: band <= band_new;
				sgfr_pkg::ADDR_THRESH: thresh <= thr_new;
				default:
					if (g_hit)
						gain[gi] <= g_new;
			endcase
		end
	// ****************************************
	// speed scheduled gain
	// ****************************************
	wire [1:0] sens_sel = ctrl[sgfr_pkg::SENS_LSB +: 2];
	wire [1:0] ramp_sel = ctrl[sgfr_pkg::RAMP_LSB +: 2];
	wire [3:0] rise_shape = ctrl[sgfr_pkg::RISE_SHAPE_LSB +: 4];
	wire [3:0] fall_shape = ctrl[sgfr_pkg::FALL_SHAPE_LSB +: 4];
	wire [15:0] spd_mag = spd_q[15] ? 16'(-spd_q) : spd_q;
	// breakpoints in 1/16 of span; point 0 is standstill
	wire [19:0] spd16 = {spd_mag, 4'h0};
	wire [15:0] bp [6];
	assign bp[0] = 16'h0000;
	assign bp[1] = {5'h00, span};
	assign bp[2] = {4'h0, span, 1'b0};
	assign bp[3] = {3'h0, span, 2'h0};
	assign bp[4] = {2'h0, span, 3'h0};
	assign bp[5] = {1'b0, span, 4'h0};
	// ****************************************
	// gain interpolation
	// ****************************************
	logic [2:0] seg;
	always_comb
	begin
		seg = 3'h0;
		for (int k = 1; k < 5; k++)
			if (spd16 >= {4'h0, bp[k]})
				seg = 3'(k);
	end
	wire past_end = spd16 >= {4'h0, bp[5]};
	wire [10:0] g_lo = gain[seg];
	wire [10:0] g_hi = gain[seg + 3'h1];
	wire [19:0] dx = spd16 - {4'h0, bp[seg]};
	wire [15:0] wid = bp[seg + 3'h1] - bp[seg];
	wire [11:0] dg = {1'b0, g_lo} - {1'b0, g_hi};
	wire [31:0] prod = 32'(dx) * 32'(dg);
	wire [31:0] quo = prod / 32'(wid);
	wire [10:0] g_int = g_lo - quo[10:0];
	wire [10:0] g_speed = past_end ? gain[5] : g_int;
	wire [10:0] g_use = (sens_sel == sgfr_pkg::SENS_SPEED) ? g_speed
		: gain[0];
	wire signed [31:0] scaled = 32'(str_q) * $signed({21'h0, g_use}) / 100;
	// scaled steer saturates at the 16-bit range
	wire signed [15:0] scaled_sat = (scaled > 32'sd32767) ? 16'sh7fff
		: (scaled < -32'sd32768) ? 16'sh8000 : scaled[15:0];
	// ****************************************
	// ramp limiter
	// ****************************************
	logic [31:0] tick_cnt;
	wire tick = tick_cnt == 32'(TICK_CYC - 1);
	sgfr_pkg::sgfr_ramp_e state, next_state;
	logic signed [15:0] flow;
	wire signed [15:0] full_s = $signed({5'h00, sgfr_pkg::FULL_FLOW});
	// requests beyond full flow are held at full flow
	wire signed [15:0] req_c = (req_q > full_s) ? full_s
		: (req_q < -full_s) ? -full_s : req_q;
	wire [15:0] req_mag = req_c[15] ? 16'(-req_c) : req_c;
	wire [15:0] flow_mag = flow[15] ? 16'(-flow) : flow;
	// from rest any request direction counts as the same direction
	wire same_dir = (req_c[15] == flow[15]) || (req_c == 16'sh0000)
		|| (flow == 16'sh0000);
	wire [15:0] tgt_mag = same_dir ? req_mag : 16'h0000;
	wire reverse = !same_dir && (flow != 16'h0000)
		&& (req_mag > {5'h00, thresh});
	wire in_fast = (flow_mag > {5'h00, band})
		&& (band != sgfr_pkg::FULL_FLOW);
	always_comb
	begin
		next_state = state;
		case (state)
			sgfr_pkg::RS_IDLE, sgfr_pkg::RS_RISE, sgfr_pkg::RS_FALL:
				if (tgt_mag > flow_mag)
					next_state = sgfr_pkg::RS_RISE;
				else if (state == sgfr_pkg::RS_FALL && reverse && !in_fast)
					next_state = sgfr_pkg::RS_ABORT;
				else if (tgt_mag < flow_mag)
					next_state = sgfr_pkg::RS_FALL;
				else
					next_state = sgfr_pkg::RS_IDLE;
			sgfr_pkg::RS_ABORT:
				if (flow == 16'h0000)
					next_state = sgfr_pkg::RS_IDLE;
			default: next_state = sgfr_pkg::RS_IDLE;
		endcase
	end
	// ****************************************
	// ramp step
	// ****************************************
	// step = full scale * tick / time, tick = 1 ms
	wire [10:0] t_act = (next_state == sgfr_pkg::RS_RISE) ? rise_ms
		: (next_state == sgfr_pkg::RS_ABORT) ? abort_ms
		: in_fast ? fast_ms : fall_ms;
	wire [15:0] base_step = 16'(32'(sgfr_pkg::FULL_FLOW) / 32'(t_act));
	wire [3:0] shp_raw = (next_state == sgfr_pkg::RS_RISE) ? rise_shape
		: (next_state == sgfr_pkg::RS_FALL && !in_fast) ? fall_shape : 4'h0;
	// shapes beyond 10 act as 10
	wire [3:0] shp = (shp_raw > 4'ha) ? 4'ha : shp_raw;
	// shape slows steps near zero flow; shape 0 stays linear
	wire [31:0] shp_num = 32'(base_step) * (32'(flow_mag) * 32'(shp)
		+ 32'(sgfr_pkg::FULL_FLOW) * 32'(11 - shp)) ;
	wire [15:0] s_raw = 16'(shp_num / (32'(sgfr_pkg::FULL_FLOW) * 32'd11));
	wire [15:0] step = (s_raw == 16'h0000) ? 16'h0001 : s_raw;
	logic [15:0] new_mag;
	always_comb
	begin
		if (next_state == sgfr_pkg::RS_RISE)
			new_mag = (tgt_mag - flow_mag > step) ? flow_mag + step : tgt_mag;
		else if (next_state == sgfr_pkg::RS_FALL
			|| next_state == sgfr_pkg::RS_ABORT)
			new_mag = (flow_mag - tgt_mag > step) ? flow_mag - step : tgt_mag;
		else
			new_mag = flow_mag;
	end
	wire flow_neg = (flow_mag == 16'h0000) ? req_c[15] : flow[15];
	wire signed [15:0] next_flow = (ramp_sel == sgfr_pkg::RAMP_OFF) ? req_c
		: flow_neg ? 16'(-new_mag) : new_mag;
	// ****************************************
	// output registers
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			tick_cnt <= 32'h0;
			state <= sgfr_pkg::RS_IDLE;
			flow <= 16'h0000;
			steer_scaled_o <= 16'h0000;
			spool_setpoint_o <= 16'h0000;
		end
		else
		begin
			tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
			steer_scaled_o <= scaled_sat;
			spool_setpoint_o <= flow;
			if (tick)
			begin
				state <= (ramp_sel == sgfr_pkg::RAMP_OFF) ? sgfr_pkg::RS_IDLE
					: next_state;
				flow <= next_flow;
			end
		end
	// ****************************************
	// bus read
	// ****************************************
	wire [31:0] rd = (wb_req_i.adr == sgfr_pkg::ADDR_CTRL) ? {16'h0, ctrl}
		: (wb_req_i.adr == sgfr_pkg::ADDR_SPAN) ? {21'h0, span}
		: (wb_req_i.adr == sgfr_pkg::ADDR_RISE_MS) ? {21'h0, rise_ms}
		: (wb_req_i.adr == sgfr_pkg::ADDR_FALL_MS) ? {21'h0, fall_ms}
		: (wb_req_i.adr == sgfr_pkg::ADDR_FAST_MS) ? {21'h0, fast_ms}
		: (wb_req_i.adr == sgfr_pkg::ADDR_ABORT_MS) ? {21'h0, abort_ms}
		: (wb_req_i.adr == sgfr_pkg::ADDR_BAND) ? {21'h0, band}
		: (wb_req_i.adr == sgfr_pkg::ADDR_THRESH) ? {21'h0, thresh}
		: (wb_req_i.adr == sgfr_pkg::ADDR_STATUS) ? {28'h0, state}
		: (wb_req_i.adr == sgfr_pkg::ADDR_GAIN_OUT) ? {21'h0, g_use}
		: (wb_req_i.adr == sgfr_pkg::ADDR_FLOW_OUT) ? {16'h0, flow}
		: g_hit ? {21'h0, gain[gi]} : 32'h0;
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= wb_hit ? rd : 32'h0;
		end
endmodule
`default_nettype wire

// >>> tb/sgfr_sva.sv
// Purpose: port checker for sgfr_top
// Assumes: one clock, bench keeps requests within full flow
// Notes: bound to every sgfr_top instance
`timescale 1ns/1ps
`default_nettype none
module sgfr_sva #(
	parameter int TICK_CYC = 20
)(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire sgfr_pkg::sgfr_wb_req_s wb_req_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic signed [15:0] road_speed_input_i,
	input wire logic signed [15:0] steer_input_i,
	input wire logic signed [15:0] requested_flow_i,
	input wire logic signed [15:0] steer_scaled_o,
	input wire logic signed [15:0] spool_setpoint_o
);
	// ****************************************
	// bus, set-point and steer checks
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_req;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	endsequence
	sequence s_steer_idle;
		(steer_input_i == 16'sh0) [*7];
	endsequence
	a_ack_answer: assert property (s_req |=> wb_ack_o)
		else $error("ack not given one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(wb_ack_o) |->
		$past(wb_req_i.cyc && wb_req_i.stb))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	a_reset_zero: assert property ($rose(reset_n_i) |->
		spool_setpoint_o == 16'sh0 && steer_scaled_o == 16'sh0)
		else $error("outputs not zero after reset");
	a_spool_tick: assert property ($changed(spool_setpoint_o) |=>
		$stable(spool_setpoint_o) [*8])
		else $error("set-point changed twice within a tick");
	a_spool_range: assert property (spool_setpoint_o <= 16'sd1000 &&
		spool_setpoint_o >= -16'sd1000)
		else $error("set-point beyond full flow");
	a_steer_zero: assert property (s_steer_idle |->
		steer_scaled_o == 16'sh0)
		else $error("scaled steer not zero for zero input");
endmodule
bind sgfr_top sgfr_sva #(.TICK_CYC(TICK_CYC)) sgfr_sva_i (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_req_i(wb_req_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.road_speed_input_i(road_speed_input_i),
	.steer_input_i(steer_input_i), .requested_flow_i(requested_flow_i),
	.steer_scaled_o(steer_scaled_o), .spool_setpoint_o(spool_setpoint_o));
`default_nettype wire

// >>> tb/sgfr_partner.sv
// Purpose: vehicle speed source facing sgfr_top
// Assumes: speed set by the bench each clock
// Notes: an unmapped source reads as zero speed
`timescale 1ns/1ps
`default_nettype none
module sgfr_partner (
	input wire logic clk_i,
	input wire logic mapped_i,
	input wire logic signed [15:0] speed_set_i,
	output logic signed [15:0] road_speed_o
);
	// ****************************************
	// speed source
	// ****************************************
	always @(posedge clk_i)
	begin
		road_speed_o <= mapped_i ? speed_set_i : 16'sh0;
	end
endmodule
`default_nettype wire

// >>> tb/sgfr_top_tb.sv
// Purpose: self-checking bench for sgfr_top
// Assumes: TICK_CYC set to 20 cycles per loop tick
// Notes: random speeds from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module sgfr_top_tb;
	// ****************************************
	// stimulus and checks
	// ****************************************
	localparam int TICK = 20;
	logic clk;
	logic reset_n;
	sgfr_pkg::sgfr_wb_req_s req;
	logic [31:0] dat;
	logic ack;
	logic mapped;
	logic signed [15:0] sp;
	logic signed [15:0] road;
	logic signed [15:0] st;
	logic signed [15:0] fl;
	logic signed [15:0] sc;
	logic signed [15:0] spool;
	logic [31:0] q;
	int fail_count = 0;
	int check_count = 0;
	int cyc_n = 0;
	int gt[6] = '{105, 90, 75, 60, 45, 30};
	int px[6] = '{0, 1, 2, 4, 8, 16};
	sgfr_top #(.TICK_CYC(TICK)) sgfr_top_i (.clk_i(clk), .reset_n_i(reset_n),
		.wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
		.road_speed_input_i(road), .steer_input_i(st),
		.requested_flow_i(fl), .steer_scaled_o(sc), .spool_setpoint_o(spool));
	sgfr_partner sgfr_partner_i (.clk_i(clk), .mapped_i(mapped),
		.speed_set_i(sp), .road_speed_o(road));
	task automatic end_sim();
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] s);
		check_count++;
		if (e !== s)
		begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	task automatic near(input string n, input int e, input logic signed [15:0] s);
		check_count++;
		if ((s - e <= 1 && e - s <= 1) !== 1'b1)
		begin
			$display("CHECK FAILED %s expected %0d seen %0d", n, e, s);
			fail_count++;
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		req <= '{dat: d, adr: a, sel: 4'hf, we: w, stb: 1'b1, cyc: 1'b1};
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dat;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic tick(input int n);
		repeat (n * TICK) @(posedge clk);
	endtask
	task automatic ramp(input logic signed [15:0] r, input int e);
		logic signed [15:0] a;
		fl <= r;
		tick(2);
		a = spool;
		tick(1);
		chk("ramp step", 16'(e), spool - a);
	endtask
	task automatic go_zero(input logic [31:0] mode);
		wb(sgfr_pkg::ADDR_CTRL, 1'b1, 32'h3);
		fl <= 16'sh0;
		tick(2);
		wb(sgfr_pkg::ADDR_CTRL, 1'b1, mode);
	endtask
	function automatic int es(input int a, input int t, input int s);
		int f;
		int r;
		f = sgfr_pkg::FULL_FLOW;
		r = (f / t) * (((a < 0) ? -a : a) * s + f * (11 - s)) / (f * 11);
		return (r == 0) ? 1 : r;
	endfunction
	task automatic sramp(input logic signed [15:0] r, input int t,
		input int s);
		logic signed [15:0] a;
		int e;
		fl <= r;
		tick(2);
		a = spool;
		e = (r > a) ? es(a, t, s) : -es(a, t, s);
		tick(1);
		chk("shaped step", 16'(e), spool - a);
	endtask
	function automatic int eg(input int v, input int span);
		int m;
		m = (v < 0) ? -v : v;
		for (int k = 0; k < 5; k++)
			if (m * 16 < span * px[k + 1])
				return gt[k] + (gt[k + 1] - gt[k]) * (m * 16 - span * px[k])
					/ (span * (px[k + 1] - px[k]));
		return gt[5];
	endfunction
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc_n++;
		if (cyc_n == 20000)
		begin
			fail_count++;
			end_sim();
		end
	end
	initial
	begin
		logic [7:0] ra[7];
		logic [15:0] rv[7];
		int cs[4];
		int v;
		ra = '{sgfr_pkg::ADDR_CTRL, sgfr_pkg::ADDR_SPAN, sgfr_pkg::ADDR_GAIN0,
			sgfr_pkg::ADDR_FALL_MS, sgfr_pkg::ADDR_BAND, sgfr_pkg::ADDR_STATUS,
			8'h44};
		rv = '{16'h1, 16'h1f4, 16'h69, 16'h15e, 16'h3e8, 16'h1, 16'h0};
		cs = '{0, -800, 50, 1000};
		req = '0;
		reset_n = 1'b0;
		mapped = 1'b1;
		sp = 16'sh0;
		st = 16'sh0;
		fl = 16'sh0;
		void'($urandom(32'h6662ee48));
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 7; i++)
		begin
			wb(ra[i], 1'b0, 32'h0);
			chk("reset value", rv[i], q[15:0]);
		end
		wb(sgfr_pkg::ADDR_SPAN, 1'b1, 32'h7d0);
		wb(sgfr_pkg::ADDR_SPAN, 1'b0, 32'h0);
		chk("span clamp", 16'h3e8, q[15:0]);
		wb(sgfr_pkg::ADDR_SPAN, 1'b1, 32'h320);
		wb(sgfr_pkg::ADDR_GAIN0, 1'b1, 32'h5);
		wb(sgfr_pkg::ADDR_GAIN0, 1'b0, 32'h0);
		chk("gain0 clamp", 16'h14, q[15:0]);
		wb(sgfr_pkg::ADDR_GAIN0, 1'b1, 32'h69);
		wb(sgfr_pkg::ADDR_THRESH, 1'b1, 32'h384);
		wb(sgfr_pkg::ADDR_THRESH, 1'b0, 32'h0);
		chk("thresh clamp", 16'h1f4, q[15:0]);
		wb(sgfr_pkg::ADDR_THRESH, 1'b1, 32'h64);
		sp <= 16'sd700;
		wb(sgfr_pkg::ADDR_CTRL, 1'b1, 32'h1);
		wb(sgfr_pkg::ADDR_GAIN_OUT, 1'b0, 32'h0);
		chk("fixed gain", 16'h69, q[15:0]);
		wb(sgfr_pkg::ADDR_CTRL, 1'b1, 32'h3);
		mapped <= 1'b0;
		repeat (10) @(posedge clk);
		wb(sgfr_pkg::ADDR_GAIN_OUT, 1'b0, 32'h0);
		chk("unmapped gain", 16'h69, q[15:0]);
		mapped <= 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			v = (i < 4) ? cs[i] : int'($urandom_range(2000)) - 1000;
			sp <= 16'(v);
			st <= (i % 2) ? -16'sd100 : 16'sd100;
			repeat (10) @(posedge clk);
			wb(sgfr_pkg::ADDR_GAIN_OUT, 1'b0, 32'h0);
			near("gain", eg(v, 800), q[15:0]);
			near("steer", (i % 2) ? -eg(v, 800) : eg(v, 800), sc);
		end
		st <= 16'sh0;
		wb(sgfr_pkg::ADDR_RISE_MS, 1'b1, 32'ha);
		wb(sgfr_pkg::ADDR_FALL_MS, 1'b1, 32'h14);
		wb(sgfr_pkg::ADDR_FAST_MS, 1'b1, 32'h5);
		wb(sgfr_pkg::ADDR_ABORT_MS, 1'b1, 32'ha);
		fl <= 16'sd600;
		tick(2);
		chk("ramp off", 16'h258, spool);
		go_zero(32'h13);
		ramp(16'sd1000, 100);
		tick(10);
		ramp(16'sh0, -50);
		ramp(-16'sd300, -100);
		wb(sgfr_pkg::ADDR_STATUS, 1'b0, 32'h0);
		chk("abort state", 16'(sgfr_pkg::RS_ABORT), q[15:0]);
		go_zero(32'h23);
		ramp(-16'sd1000, -100);
		go_zero(32'h13);
		wb(sgfr_pkg::ADDR_BAND, 1'b1, 32'h1f4);
		fl <= 16'sd1000;
		tick(12);
		ramp(16'sh0, -200);
		wb(sgfr_pkg::ADDR_BAND, 1'b1, 32'h3e8);
		go_zero(32'h5513);
		sramp(16'sd1000, 10, 5);
		tick(14);
		sramp(16'sh0, 20, 5);
		end_sim();
	end
endmodule
`default_nettype wire
